// *** logic/cevs_pkg.sv ***
// Constants for the channel enable and voltage select register bank
package cevs_pkg;
  // Register offsets
  localparam logic [7:0] OFS_ENABLE  = 8'h01;
  localparam logic [7:0] OFS_VSEL1   = 8'h02;
  localparam logic [7:0] OFS_VSEL23  = 8'h03;
  // Reset values and field positions
  localparam logic [7:0] ENABLE_RST  = 8'h0f;
  localparam int         NUM_CHAN    = 4;
  localparam int         CH1_LSB     = 0;
  localparam int         CH1_W       = 5;
  localparam int         CH2_LSB     = 0;
  localparam int         CH3_LSB     = 4;
  localparam int         CH23_W      = 3;
  // Voltage decoding in millivolts
  localparam int         MV_W        = 13;
  localparam int         ADJ_MV      = 800;
  localparam int         CH1_BASE_MV = 825;
  localparam int         CH1_STEP_MV = 25;
  localparam int         CH2_BASE_MV = 3000;
  localparam int         CH2_STEP_MV = 300;
  localparam logic [2:0] CH2_TOP     = 3'h7;
  localparam int         CH2_TOP_MV  = 5000;
  localparam int         CH3_BASE_MV = 1100;
  localparam int         CH3_STEP_MV = 100;
  // Serial interface
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } cevs_state_type;
endpackage

// *** logic/cevs_sync.sv ***
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module cevs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Pins and synchronised copy
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stage1   <= '0;
      pin_sync <= '0;
    end
    else
    begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end
endmodule

// *** logic/cevs_regs.sv ***
// Channel enable and voltage select registers behind a two-wire serial slave
`timescale 1ns/1ns
module cevs_regs #(
  parameter logic [6:0] DEV_ADDR = cevs_pkg::DEV_ADDR_DEF
) (
  // Clock and power-on reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Two-wire serial pins, data is open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Hardware enable pins, channel 1 in bit 0
  input  wire logic [3:0]  chan_hw_enable_pin,
  // Factory fuse defaults
  input  wire logic [4:0]  fuse_chan1_code,
  input  wire logic [2:0]  fuse_chan2_code,
  input  wire logic [2:0]  fuse_chan3_code,
  // Regulator controls
  output logic      [3:0]  chan_run,
  output logic      [4:0]  chan1_volt_code,
  output logic      [2:0]  chan2_volt_code,
  output logic      [2:0]  chan3_volt_code,
  output logic      [12:0] chan1_mv,
  output logic      [12:0] chan2_mv,
  output logic      [12:0] chan3_mv
);
  logic [3:0]  en_s;
  logic [1:0]  bus_s;
  logic [10:0] fuse_s;
  logic        scl_prev;
  logic        sda_prev;
  logic [7:0]  channel_enable_ctrl;
  logic [7:0]  ch1_voltage_select;
  logic [7:0]  ch2_ch3_voltage_select;
  cevs_pkg::cevs_state_type state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  rdsh;
  logic [7:0]  ptr;
  logic        rw;
  logic        mnack;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;

  // Pin synchronisers
  cevs_sync #(.WIDTH(4)) u_en_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .pin_in   (chan_hw_enable_pin),
    .pin_sync (en_s)
  );
  // Bus and fuse copies are never cleared: an idle bus must not read as low after
  // reset, and the fuse values must be settled while the reset captures them
  cevs_sync #(.WIDTH(2)) u_bus_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (1'b0),
    .pin_in   ({scl_in, sda_in}),
    .pin_sync (bus_s)
  );
  cevs_sync #(.WIDTH(11)) u_fuse_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (1'b0),
    .pin_in   ({fuse_chan3_code, fuse_chan2_code, fuse_chan1_code}),
    .pin_sync (fuse_s)
  );

  // Bus line events
  wire scl_s     = bus_s[1];
  wire sda_s     = bus_s[0];
  wire scl_rise  = scl_s & ~scl_prev;
  wire scl_fall  = ~scl_s & scl_prev;
  wire bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
  wire bus_stop  = scl_s & scl_prev & ~sda_prev & sda_s;
  wire byte_done = scl_fall && (bit_cnt == cevs_pkg::BITS_PER_BYTE);
  wire addr_hit  = (shreg[7:1] == DEV_ADDR);

  // Register read selection, unmapped offsets read zero
  wire [7:0] rd_word = (ptr == cevs_pkg::OFS_ENABLE) ? channel_enable_ctrl :
                       (ptr == cevs_pkg::OFS_VSEL1)  ? ch1_voltage_select :
                       (ptr == cevs_pkg::OFS_VSEL23) ? ch2_ch3_voltage_select : 8'h00;

  // Write decode
  wire wr_ctrl  = wr_en && (wr_addr == cevs_pkg::OFS_ENABLE);
  wire wr_vsel1 = wr_en && (wr_addr == cevs_pkg::OFS_VSEL1);
  wire wr_vs23  = wr_en && (wr_addr == cevs_pkg::OFS_VSEL23);

  // Enable bits follow a write only where the pin is high, else snap to 1
  wire [3:0] ctrl_wr_val = wr_ctrl ? wr_data[3:0] : channel_enable_ctrl[3:0];
  wire [3:0] next_run_bits = ctrl_wr_val | ~en_s;

  assign sda_out = 1'b0;
  assign chan_run = channel_enable_ctrl[3:0] & en_s;
  assign chan1_volt_code = ch1_voltage_select[cevs_pkg::CH1_LSB +: cevs_pkg::CH1_W];
  assign chan2_volt_code = ch2_ch3_voltage_select[cevs_pkg::CH2_LSB +: cevs_pkg::CH23_W];
  assign chan3_volt_code = ch2_ch3_voltage_select[cevs_pkg::CH3_LSB +: cevs_pkg::CH23_W];

  // Edge history of the synchronised bus lines
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // Register bank
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      channel_enable_ctrl    <= cevs_pkg::ENABLE_RST;
      ch1_voltage_select     <= {3'h0, fuse_s[4:0]};
      ch2_ch3_voltage_select <= {1'b0, fuse_s[10:8], 1'b0, fuse_s[7:5]};
    end
    else
    begin
      channel_enable_ctrl <= {wr_ctrl ? wr_data[7:4] : channel_enable_ctrl[7:4],
                              next_run_bits};
      if (wr_vsel1)
        ch1_voltage_select <= wr_data;
      if (wr_vs23)
        ch2_ch3_voltage_select <= wr_data;
    end
  end

  // Decoded output voltages, 25 mV steps on channel 1
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      chan1_mv <= '0;
      chan2_mv <= '0;
      chan3_mv <= '0;
    end
    else
    begin
      chan1_mv <= (chan1_volt_code == 5'h00) ? 13'(cevs_pkg::ADJ_MV) :
        13'(cevs_pkg::CH1_BASE_MV + cevs_pkg::CH1_STEP_MV * int'(chan1_volt_code));
      chan2_mv <= (chan2_volt_code == 3'h0) ? 13'(cevs_pkg::ADJ_MV) :
        (chan2_volt_code == cevs_pkg::CH2_TOP) ? 13'(cevs_pkg::CH2_TOP_MV) :
        13'(cevs_pkg::CH2_BASE_MV + cevs_pkg::CH2_STEP_MV * int'(chan2_volt_code));
      chan3_mv <= (chan3_volt_code == 3'h0) ? 13'(cevs_pkg::ADJ_MV) :
        13'(cevs_pkg::CH3_BASE_MV + cevs_pkg::CH3_STEP_MV * int'(chan3_volt_code));
    end
  end

  // Serial slave: bits sampled on clock rise, data changed on clock fall
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state   <= cevs_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      rdsh    <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      mnack   <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_en <= 1'b0;
      if (bus_start)
      begin
        state   <= cevs_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end
      else if (bus_stop)
      begin
        state  <= cevs_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (state)
          cevs_pkg::ST_ADDR, cevs_pkg::ST_PTR, cevs_pkg::ST_WR:
          begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          cevs_pkg::ST_RD:
            bit_cnt <= bit_cnt + 4'h1;
          cevs_pkg::ST_ACK_RD:
            mnack <= sda_s;
          default:
            bit_cnt <= bit_cnt;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          cevs_pkg::ST_ADDR:
            if (byte_done)
            begin
              bit_cnt <= 4'h0;
              rw      <= shreg[0];
              state   <= addr_hit ? cevs_pkg::ST_ACK_ADDR : cevs_pkg::ST_IDLE;
              sda_oe  <= addr_hit;
            end
          cevs_pkg::ST_ACK_ADDR:
            if (rw)
            begin
              state  <= cevs_pkg::ST_RD;
              rdsh   <= rd_word;
              sda_oe <= ~rd_word[7];
            end
            else
            begin
              state  <= cevs_pkg::ST_PTR;
              sda_oe <= 1'b0;
            end
          cevs_pkg::ST_PTR:
            if (byte_done)
            begin
              bit_cnt <= 4'h0;
              ptr     <= shreg;
              state   <= cevs_pkg::ST_ACK_PTR;
              sda_oe  <= 1'b1;
            end
          cevs_pkg::ST_WR:
            if (byte_done)
            begin
              bit_cnt <= 4'h0;
              wr_en   <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h01;
              state   <= cevs_pkg::ST_ACK_WR;
              sda_oe  <= 1'b1;
            end
          cevs_pkg::ST_ACK_PTR, cevs_pkg::ST_ACK_WR:
          begin
            state  <= cevs_pkg::ST_WR;
            sda_oe <= 1'b0;
          end
          cevs_pkg::ST_RD:
            if (byte_done)
            begin
              bit_cnt <= 4'h0;
              ptr     <= ptr + 8'h01;
              state   <= cevs_pkg::ST_ACK_RD;
              sda_oe  <= 1'b0;
            end
            else
              sda_oe <= ~rdsh[3'(4'h7 - bit_cnt)];
          cevs_pkg::ST_ACK_RD:
            if (mnack)
              state <= cevs_pkg::ST_IDLE;
            else
            begin
              state  <= cevs_pkg::ST_RD;
              rdsh   <= rd_word;
              sda_oe <= ~rd_word[7];
            end
          default:
            sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // Checks
  property p_run_needs_pin;
    @(posedge ref_clk) disable iff (sys_rst) (chan_run & ~en_s) == 4'h0;
  endproperty
  a_run_needs_pin: assert property (p_run_needs_pin) else $error("run without pin");

  property p_reset_enable;
    @(posedge ref_clk) $past(sys_rst) |-> channel_enable_ctrl == cevs_pkg::ENABLE_RST;
  endproperty
  a_reset_enable: assert property (p_reset_enable) else $error("enable reset wrong");

  property p_write_pin_low;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_ctrl |=> &(channel_enable_ctrl[3:0] | $past(en_s));
  endproperty
  a_write_pin_low: assert property (p_write_pin_low) else $error("disabled with pin low");

  property p_pin_low_forces;
    @(posedge ref_clk) disable iff (sys_rst)
      en_s != 4'hf |=> &(channel_enable_ctrl[3:0] | $past(en_s));
  endproperty
  a_pin_low_forces: assert property (p_pin_low_forces) else $error("bit not forced");

  property p_ctrl_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_ctrl && en_s == 4'hf ##1 en_s == 4'hf |-> channel_enable_ctrl == $past(wr_data);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable write lost");

  property p_vsel1_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_vsel1 |=> chan1_volt_code == $past(wr_data[4:0])
        ##1 ((chan1_mv == 13'(cevs_pkg::ADJ_MV)) == (chan1_volt_code == 5'h00));
  endproperty
  a_vsel1_write: assert property (p_vsel1_write) else $error("ch1 code wrong");

  property p_vsel3_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_vs23 |=> chan3_volt_code == $past(wr_data[6:4]);
  endproperty
  a_vsel3_write: assert property (p_vsel3_write) else $error("ch3 code wrong");

  property p_vsel2_write;
    @(posedge ref_clk) disable iff (sys_rst)
      wr_vs23 && wr_data[2:0] == 3'h7 |=> ##1 chan2_mv == 13'(cevs_pkg::CH2_TOP_MV);
  endproperty
  a_vsel2_write: assert property (p_vsel2_write) else $error("ch2 top code wrong");

  property p_fuse_reset;
    @(posedge ref_clk) $fell(sys_rst) |-> chan1_volt_code == $past(fuse_s[4:0]);
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) else $error("fuse default lost");

  property p_ch1_step;
    @(posedge ref_clk) disable iff (sys_rst)
      chan1_volt_code == 5'h13 ##1 chan1_volt_code == 5'h13 |-> chan1_mv == 13'h0514;
  endproperty
  a_ch1_step: assert property (p_ch1_step) else $error("ch1 1.3 V wrong");
endmodule

// *** sim/cevs_host.sv ***
// Two-wire serial host model driving the register bank's bus
`timescale 1ns/1ns
module cevs_host #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic ref_clk,
  // Bus lines, data is open drain with a pull-up
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  // Idle bus with both lines released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Hold the line levels for one bus phase, then step off the edge
  task automatic phase();
    repeat (HALF) @(posedge ref_clk);
    #1;
  endtask

  // Start or repeated start, leaves the clock low
  task automatic start();
    sda_low = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sda_low = 1'b1;
    phase();
    scl = 1'b0;
    phase();
  endtask

  // One bit: data set while the clock is low, sampled late in the high phase
  task automatic bit_xfer(input logic tx, output logic rx);
    sda_low = ~tx;
    phase();
    scl = 1'b1;
    phase();
    rx = sda_wire;
    scl = 1'b0;
    phase();
  endtask

  // Eight bits MSB first and the acknowledge bit
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_xfer(tx[i], rx[i]);
    bit_xfer(ack_in, ack);
  endtask

  // Stop condition, leaves the bus idle
  task automatic stop();
    sda_low = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sda_low = 1'b0;
    phase();
  endtask

  // Register write, nack is high if any byte went unacknowledged
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] val, output logic nack);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer_byte({dev, 1'b0}, 1'b1, rx, a0);
    xfer_byte(ofs, 1'b1, rx, a1);
    xfer_byte(val, 1'b1, rx, a2);
    stop();
    nack = a0 | a1 | a2;
  endtask

  // Register read through a repeated start, host ends with a NACK
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          output logic [7:0] val);
    logic [7:0] rx;
    logic       a;
    start();
    xfer_byte({dev, 1'b0}, 1'b1, rx, a);
    xfer_byte(ofs, 1'b1, rx, a);
    start();
    xfer_byte({dev, 1'b1}, 1'b1, rx, a);
    xfer_byte(8'hff, 1'b1, val, a);
    stop();
  endtask
endmodule

// *** sim/channel_enable_and_voltage_select_regs_bench.sv ***
// Self-checking bench for the channel enable and voltage select register bank
`timescale 1ns/1ns
module channel_enable_and_voltage_select_regs_bench;
  localparam logic [6:0] DEV = cevs_pkg::DEV_ADDR_DEF;
  localparam logic [4:0] F1  = 5'h0b;
  localparam logic [2:0] F2  = 3'h5;
  localparam logic [2:0] F3  = 3'h6;
  logic        ref_clk;
  logic        sys_rst;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic [3:0]  pins;
  logic [3:0]  chan_run;
  logic [4:0]  c1;
  logic [2:0]  c2;
  logic [2:0]  c3;
  logic [12:0] mv1;
  logic [12:0] mv2;
  logic [12:0] mv3;
  logic [7:0]  rd;
  logic        nack;
  logic [4:0]  list1 [5] = '{5'h00, 5'h01, 5'h07, 5'h13, 5'h1f};
  int          num_errors = 0;
  int          cmp_count = 0;
  wire         sda_wire;

  // Wired-AND data line with pull-up
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

  // Design and host
  cevs_regs cevs_regs_i (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .scl_in             (scl),
    .sda_in             (sda_wire),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .chan_hw_enable_pin (pins),
    .fuse_chan1_code    (F1),
    .fuse_chan2_code    (F2),
    .fuse_chan3_code    (F3),
    .chan_run           (chan_run),
    .chan1_volt_code    (c1),
    .chan2_volt_code    (c2),
    .chan3_volt_code    (c3),
    .chan1_mv           (mv1),
    .chan2_mv           (mv2),
    .chan3_mv           (mv3)
  );
  cevs_host cevs_host_i (
    .ref_clk  (ref_clk),
    .scl      (scl),
    .sda_low  (sda_low),
    .sda_wire (sda_wire)
  );

  // Clock at 250 MHz
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Comparisons
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_mv(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: millivolts %h expected %h", $time, got, exp);
    end
  endtask

  // Expected millivolts: code 0 is the adjustable point, then fixed steps
  function automatic logic [12:0] mv_of(input logic [4:0] code, input logic [12:0] first,
                                        input logic [12:0] step);
    if (code == 5'h00)
      return 13'h320;
    return first + step * (13'(code) - 13'h001);
  endfunction

  // Bus and timing helpers
  task automatic settle();
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    cevs_host_i.write_reg(DEV, ofs, val, nack);
    cmp_byte({7'h00, nack}, 8'h00);
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    cevs_host_i.read_reg(DEV, ofs, rd);
    cmp_byte(rd, exp);
  endtask

  // Reset pulse and the state that must follow it
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    settle();
    cmp_byte({4'h0, chan_run}, {4'h0, pins});
    cmp_byte({3'h0, c1}, {3'h0, F1});
    cmp_byte({1'b0, c3, 1'b0, c2}, {1'b0, F3, 1'b0, F2});
    cmp_mv(mv1, mv_of(F1, 13'h352, 13'h019));
    rd_chk(cevs_pkg::OFS_ENABLE, 8'h0f);
    rd_chk(cevs_pkg::OFS_VSEL1, {3'h0, F1});
    rd_chk(cevs_pkg::OFS_VSEL23, {1'b0, F3, 1'b0, F2});
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #200000;
    num_errors++;
    wrap_up();
  end

  // Test sequence
  initial
  begin
    sys_rst = 1'b1;
    pins = 4'hf;
    do_reset();
    wr(cevs_pkg::OFS_ENABLE, 8'ha5);
    rd_chk(cevs_pkg::OFS_ENABLE, 8'ha5);
    cmp_byte({4'h0, chan_run}, 8'h05);
    pins = 4'hd;
    settle();
    cmp_byte({4'h0, chan_run}, 8'h05);
    rd_chk(cevs_pkg::OFS_ENABLE, 8'ha7);
    wr(cevs_pkg::OFS_ENABLE, 8'h00);
    rd_chk(cevs_pkg::OFS_ENABLE, 8'h02);
    pins = 4'hf;
    settle();
    cmp_byte({4'h0, chan_run}, 8'h02);
    foreach (list1[i])
    begin
      wr(cevs_pkg::OFS_VSEL1, {3'h7, list1[i]});
      rd_chk(cevs_pkg::OFS_VSEL1, {3'h7, list1[i]});
      cmp_byte({3'h0, c1}, {3'h0, list1[i]});
      cmp_mv(mv1, mv_of(list1[i], 13'h352, 13'h019));
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(cevs_pkg::OFS_VSEL23, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
      rd_chk(cevs_pkg::OFS_VSEL23, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
      cmp_byte({1'b0, c3, 1'b0, c2}, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
      cmp_mv(mv2, (c == 7) ? 13'h1388 : mv_of(5'(c), 13'hce4, 13'h12c));
      cmp_mv(mv3, mv_of(5'(7 - c), 13'h4b0, 13'h064));
    end
    // Unmapped offset and a foreign device address
    cevs_host_i.write_reg(DEV, 8'h05, 8'h5a, nack);
    rd_chk(8'h05, 8'h00);
    cevs_host_i.start();
    cevs_host_i.xfer_byte({7'h15, 1'b0}, 1'b1, rd, nack);
    cevs_host_i.stop();
    cmp_byte({7'h00, nack}, 8'h01);
    do_reset();
    wrap_up();
  end
endmodule
